/* File: design/vic_pkg.sv */
package vic_pkg;
  localparam int VIC_NUM_TRAPS = 8;
  localparam int VIC_NUM_IRQS = 118;
  localparam int VIC_NUM_VEC = 126;
  localparam int VIC_IDX_W = 7;
  localparam int VIC_LVL_W = 3;
  localparam int VIC_ADDR_W = 24;
  // word address of the first entry of the primary table
  localparam logic [23:0] VIC_PRI_BASE = 24'h00_0004;
  localparam logic [23:0] VIC_ALT_OFFSET = 24'h00_0100;
  localparam logic [23:0] VIC_RESET_ADDR = 24'h00_0000;
  localparam int VIC_ALT_SEL_BIT = 15;
  // traps sit above every user level
  localparam logic [3:0] VIC_TRAP_LEVEL = 4'h8;
  localparam logic [3:0] VIC_LEVEL_OFF = 4'h0;
  // cycles from a return strobe back to arbitration
  localparam int VIC_RET_CYCLES = 2;
  localparam logic [1:0] VIC_RET_LOAD = 2'(VIC_RET_CYCLES - 1);

  typedef enum logic [4:0] {
    VIC_IDLE = 5'b0_0001,
    VIC_FETCH = 5'b0_0010,
    VIC_LOAD = 5'b0_0100,
    VIC_REQ = 5'b0_1000,
    VIC_SERV = 5'b1_0000
  } vic_state_t;

  typedef struct packed {
    logic valid;
    logic [6:0] idx;
    logic [23:0] isr_addr;
  } vic_req_t;

  typedef struct packed {
    logic rd;
    logic [23:0] addr;
  } vic_fetch_t;
endpackage : vic_pkg

/* File: design/vic_arbiter.sv */
module vic_arbiter
  import vic_pkg::*;
(
  input wire logic [125:0] pend_i,
  input wire logic [117:0][2:0] prio_i,
  input wire logic [2:0] cpu_ipl_i,
  output logic win_valid_o,
  output logic [6:0] win_idx_o,
  output logic [3:0] win_lvl_o
);
  logic [125:0][3:0] eff_lvl;

  genvar g;
  generate
    for (g = 0; g < VIC_NUM_VEC; g++) begin : g_lvl
      if (g < VIC_NUM_TRAPS) begin : g_trap
        // traps cannot be masked
        assign eff_lvl[g] = pend_i[g] ? VIC_TRAP_LEVEL : VIC_LEVEL_OFF;
      end else begin : g_irq
        assign eff_lvl[g] = pend_i[g] ? {1'b0, prio_i[g - VIC_NUM_TRAPS]} : VIC_LEVEL_OFF;
      end
    end
  endgenerate

  // scan downward so that on equal level the lower vector wins
  always_comb begin
    win_lvl_o = VIC_LEVEL_OFF;
    win_idx_o = 7'h00;
    for (int i = VIC_NUM_VEC - 1; i >= 0; i--) begin
      if (eff_lvl[i] != VIC_LEVEL_OFF && eff_lvl[i] >= win_lvl_o) begin
        win_lvl_o = eff_lvl[i];
        win_idx_o = 7'(i);
      end
    end
    win_valid_o = win_lvl_o > {1'b0, cpu_ipl_i};
  end
endmodule : vic_arbiter

/* File: design/vic_top.sv */
module vic_top
  import vic_pkg::*;
(
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire logic [125:0] pend_i,
  input wire logic [117:0][2:0] prio_i,
  input wire logic [2:0] cpu_ipl_i,
  input wire logic [15:0] interrupt_control_second_i,
  input wire logic [23:0] pm_rdata_i,
  input wire logic irq_ack_i,
  input wire logic irq_ret_i,
  output vic_pkg::vic_req_t irq_o,
  output vic_pkg::vic_fetch_t fetch_o,
  output logic clr_o,
  output logic [6:0] clr_idx_o
);
  import vic_pkg::*;

  logic win_valid;
  logic [6:0] win_idx;
  logic [3:0] win_lvl;
  logic alt_table_select;

  vic_state_t state_r, state_nxt;
  vic_req_t irq_r, irq_nxt;
  vic_fetch_t fetch_r, fetch_nxt;
  logic alt_r, alt_nxt;
  logic clr_r, clr_nxt;
  logic [6:0] clr_idx_r, clr_idx_nxt;
  logic [1:0] ret_cnt_r, ret_cnt_nxt;

  vic_arbiter u_arb (
    .pend_i(pend_i),
    .prio_i(prio_i),
    .cpu_ipl_i(cpu_ipl_i),
    .win_valid_o(win_valid),
    .win_idx_o(win_idx),
    .win_lvl_o(win_lvl)
  );

  assign alt_table_select = interrupt_control_second_i[VIC_ALT_SEL_BIT];

  always_comb begin
    state_nxt = state_r;
    irq_nxt = irq_r;
    fetch_nxt = fetch_r;
    alt_nxt = alt_r;
    clr_nxt = 1'b0;
    clr_idx_nxt = clr_idx_r;
    ret_cnt_nxt = ret_cnt_r;
    case (state_r)
      VIC_IDLE: begin
        if (win_valid) begin
          irq_nxt.idx = win_idx;
          alt_nxt = alt_table_select;
          fetch_nxt.rd = 1'b1;
          // one entry per vector, alternate copy at a fixed offset
          fetch_nxt.addr = VIC_PRI_BASE + {16'h0000, win_idx, 1'b0}
            + (alt_table_select ? VIC_ALT_OFFSET : VIC_RESET_ADDR);
          state_nxt = VIC_FETCH;
        end
      end
      VIC_FETCH: begin
        // program memory answers one cycle after the read strobe
        fetch_nxt.rd = 1'b0;
        state_nxt = VIC_LOAD;
      end
      VIC_LOAD: begin
        irq_nxt.isr_addr = pm_rdata_i;
        irq_nxt.valid = 1'b1;
        state_nxt = VIC_REQ;
      end
      VIC_REQ: begin
        // the request stands unchanged, with no new arbitration, until the CPU takes it
        if (irq_ack_i) begin
          irq_nxt.valid = 1'b0;
          clr_nxt = 1'b1;
          clr_idx_nxt = irq_r.idx;
          ret_cnt_nxt = VIC_RET_LOAD;
          state_nxt = VIC_SERV;
        end
      end
      VIC_SERV: begin
        // no nesting: a new request waits for the return strobe
        if (irq_ret_i && ret_cnt_r == VIC_RET_LOAD) begin
          ret_cnt_nxt = ret_cnt_r - 2'd1;
        end else if (ret_cnt_r != VIC_RET_LOAD) begin
          if (ret_cnt_r == 2'd0) begin
            state_nxt = VIC_IDLE;
            ret_cnt_nxt = VIC_RET_LOAD;
          end else begin
            ret_cnt_nxt = ret_cnt_r - 2'd1;
          end
        end
      end
      default: begin
        state_nxt = VIC_IDLE;
      end
    endcase
  end

  // reset is synchronous and plain: it never passes through arbitration
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      state_r <= VIC_IDLE;
      irq_r <= '0;
      fetch_r <= '{rd: 1'b0, addr: VIC_RESET_ADDR};
      alt_r <= 1'b0;
      clr_r <= 1'b0;
      clr_idx_r <= 7'h00;
      ret_cnt_r <= VIC_RET_LOAD;
    end else begin
      state_r <= state_nxt;
      irq_r <= irq_nxt;
      fetch_r <= fetch_nxt;
      alt_r <= alt_nxt;
      clr_r <= clr_nxt;
      clr_idx_r <= clr_idx_nxt;
      ret_cnt_r <= ret_cnt_nxt;
    end
  end

  assign irq_o = irq_r;
  assign fetch_o = fetch_r;
  assign clr_o = clr_r;
  assign clr_idx_o = clr_idx_r;

  property p_single_req;
    @(posedge clk_sys_i) disable iff (rst_i)
    irq_o.valid && !irq_ack_i |=> irq_o.valid && $stable(irq_o.idx) && $stable(irq_o.isr_addr);
  endproperty
  a_single_req: assert property (p_single_req) else $error("request dropped or changed before ack");

  property p_level;
    @(posedge clk_sys_i) disable iff (rst_i)
    win_valid |-> win_lvl > {1'b0, cpu_ipl_i} && win_lvl <= VIC_TRAP_LEVEL;
  endproperty
  a_level: assert property (p_level) else $error("winner not above cpu level");

  property p_pri_addr;
    @(posedge clk_sys_i) disable iff (rst_i)
    $rose(fetch_o.rd) && !alt_r |-> fetch_o.addr == VIC_PRI_BASE + {16'h0000, irq_o.idx, 1'b0};
  endproperty
  a_pri_addr: assert property (p_pri_addr) else $error("primary entry address wrong");

  property p_idx_range;
    @(posedge clk_sys_i) disable iff (rst_i)
    win_valid |-> win_idx < 7'(VIC_NUM_VEC);
  endproperty
  a_idx_range: assert property (p_idx_range) else $error("winner index outside table");

  property p_isr_addr;
    @(posedge clk_sys_i) disable iff (rst_i)
    $rose(irq_o.valid) |-> irq_o.isr_addr == $past(pm_rdata_i);
  endproperty
  a_isr_addr: assert property (p_isr_addr) else $error("routine address not from table");

  property p_vec0_wins;
    @(posedge clk_sys_i) disable iff (rst_i)
    pend_i[0] |-> win_valid && win_idx == 7'h00;
  endproperty
  a_vec0_wins: assert property (p_vec0_wins) else $error("vector 0 did not win");

  property p_alt_addr;
    @(posedge clk_sys_i) disable iff (rst_i)
    $rose(fetch_o.rd) && alt_r |-> fetch_o.addr == VIC_PRI_BASE + VIC_ALT_OFFSET + {16'h0000, irq_o.idx, 1'b0};
  endproperty
  a_alt_addr: assert property (p_alt_addr) else $error("alternate entry address wrong");

  property p_reset;
    @(posedge clk_sys_i)
    rst_i |=> !irq_o.valid && !fetch_o.rd && !clr_o && fetch_o.addr == VIC_RESET_ADDR;
  endproperty
  a_reset: assert property (p_reset) else $error("outputs not cleared by reset");

  property p_entry_lat;
    @(posedge clk_sys_i) disable iff (rst_i)
    $rose(fetch_o.rd) |=> !fetch_o.rd && !irq_o.valid ##1 irq_o.valid;
  endproperty
  a_entry_lat: assert property (p_entry_lat) else $error("entry latency not fixed");

  property p_ret_lat;
    @(posedge clk_sys_i) disable iff (rst_i)
    state_r == VIC_SERV && irq_ret_i && ret_cnt_r == VIC_RET_LOAD |-> ##2 state_r == VIC_IDLE;
  endproperty
  a_ret_lat: assert property (p_ret_lat) else $error("return latency not fixed");

  property p_clr_after_ack;
    @(posedge clk_sys_i) disable iff (rst_i)
    clr_o |-> $past(irq_ack_i) && $past(irq_o.valid) && clr_idx_o == $past(irq_o.idx);
  endproperty
  a_clr_after_ack: assert property (p_clr_after_ack) else $error("source cleared without ack");

  // sequencing of the take, the standing request and its release
  property p_rd_pulse;
    @(posedge clk_sys_i) disable iff (rst_i)
    fetch_o.rd |=> !fetch_o.rd;
  endproperty
  a_rd_pulse: assert property (p_rd_pulse) else $error("table read strobe longer than one cycle");

  property p_take_idle;
    @(posedge clk_sys_i) disable iff (rst_i)
    $rose(fetch_o.rd) |-> $past(state_r) == VIC_IDLE && $past(win_valid);
  endproperty
  a_take_idle: assert property (p_take_idle) else $error("table read without a winner in idle");

  property p_take_idx;
    @(posedge clk_sys_i) disable iff (rst_i)
    $rose(fetch_o.rd) |-> irq_o.idx == $past(win_idx);
  endproperty
  a_take_idx: assert property (p_take_idx) else $error("taken index differs from winner");

  property p_idle_quiet;
    @(posedge clk_sys_i) disable iff (rst_i)
    state_r == VIC_IDLE && !win_valid |=> !fetch_o.rd && state_r == VIC_IDLE;
  endproperty
  a_idle_quiet: assert property (p_idle_quiet) else $error("take without a pending winner");

  property p_trap_first;
    @(posedge clk_sys_i) disable iff (rst_i)
    (|pend_i[7:0]) |-> win_valid && win_idx < 7'(VIC_NUM_TRAPS);
  endproperty
  a_trap_first: assert property (p_trap_first) else $error("trap lost to an interrupt source");

  property p_alt_latch;
    @(posedge clk_sys_i) disable iff (rst_i)
    $rose(fetch_o.rd) |-> alt_r == $past(alt_table_select);
  endproperty
  a_alt_latch: assert property (p_alt_latch) else $error("table select not taken with the winner");

  property p_pri_range;
    @(posedge clk_sys_i) disable iff (rst_i)
    $rose(fetch_o.rd) && !alt_r |-> fetch_o.addr < VIC_PRI_BASE + 24'(2 * VIC_NUM_VEC);
  endproperty
  a_pri_range: assert property (p_pri_range) else $error("primary entry beyond its table");

  property p_state_onehot;
    @(posedge clk_sys_i) disable iff (rst_i)
    $onehot(state_r);
  endproperty
  a_state_onehot: assert property (p_state_onehot) else $error("sequencer state not one-hot");

  property p_valid_in_req;
    @(posedge clk_sys_i) disable iff (rst_i)
    irq_o.valid |-> state_r == VIC_REQ;
  endproperty
  a_valid_in_req: assert property (p_valid_in_req) else $error("request standing outside request state");

  property p_no_nest;
    @(posedge clk_sys_i) disable iff (rst_i)
    state_r != VIC_IDLE |=> !fetch_o.rd;
  endproperty
  a_no_nest: assert property (p_no_nest) else $error("new take while busy");

  property p_ack_release;
    @(posedge clk_sys_i) disable iff (rst_i)
    irq_o.valid && irq_ack_i |=> !irq_o.valid && clr_o && state_r == VIC_SERV;
  endproperty
  a_ack_release: assert property (p_ack_release) else $error("acknowledge did not release the request");

  property p_clr_pulse;
    @(posedge clk_sys_i) disable iff (rst_i)
    clr_o |=> !clr_o;
  endproperty
  a_clr_pulse: assert property (p_clr_pulse) else $error("clear strobe longer than one cycle");

  property p_clr_idx_hold;
    @(posedge clk_sys_i) disable iff (rst_i)
    !clr_o && !$past(rst_i) |-> $stable(clr_idx_o);
  endproperty
  a_clr_idx_hold: assert property (p_clr_idx_hold) else $error("cleared index changed without a take");

  property p_serv_wait;
    @(posedge clk_sys_i) disable iff (rst_i)
    state_r == VIC_SERV && !irq_ret_i && ret_cnt_r == VIC_RET_LOAD |=> state_r == VIC_SERV;
  endproperty
  a_serv_wait: assert property (p_serv_wait) else $error("service left without a return");

  property p_reset_state;
    @(posedge clk_sys_i)
    rst_i |=> state_r == VIC_IDLE && clr_idx_o == 7'h00 && ret_cnt_r == VIC_RET_LOAD;
  endproperty
  a_reset_state: assert property (p_reset_state) else $error("sequencer not cleared by reset");

  c_trap: cover property (@(posedge clk_sys_i) disable iff (rst_i) $rose(irq_o.valid) && irq_o.idx < 7'(VIC_NUM_TRAPS));
  c_alt: cover property (@(posedge clk_sys_i) disable iff (rst_i) $rose(fetch_o.rd) && alt_r);
  c_ack: cover property (@(posedge clk_sys_i) disable iff (rst_i) clr_o);
  c_return: cover property (@(posedge clk_sys_i) disable iff (rst_i) state_r == VIC_SERV ##1 state_r == VIC_IDLE);
endmodule : vic_top

/* File: test/vic_cpu_model.sv */
module vic_cpu_model
  import vic_pkg::*;
(
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire vic_pkg::vic_req_t irq_i,
  input wire vic_pkg::vic_fetch_t fetch_i,
  input wire logic [3:0] dly_i,
  output logic [23:0] pm_rdata_o,
  output logic irq_ack_o,
  output logic irq_ret_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] cnt_r;
  logic [4:0] rc_r;
  always_ff @(posedge clk_sys_i) begin
    // word valid only in the cycle after the strobe, scrambled otherwise
    pm_rdata_o <= fetch_i.rd ? (fetch_i.addr ^ 24'hA5_0000) : ~pm_rdata_o;
    irq_ret_o <= 1'b0;
    if (rst_i) begin
      pm_rdata_o <= 24'h5A_5A5A;
      irq_ack_o <= 1'b0;
      cnt_r <= 4'h0;
      rc_r <= 5'h0;
    end else if (irq_ack_o) begin
      irq_ack_o <= 1'b0;
      cnt_r <= 4'h0;
      rc_r <= 5'(dly_i) + 5'h1;
    end else if (irq_i.valid) begin
      // slow cpu: acknowledge only after dly_i + 1 cycles of a standing request
      if (cnt_r == dly_i) irq_ack_o <= 1'b1;
      else cnt_r <= cnt_r + 4'h1;
    end else if (rc_r != 5'h0) begin
      rc_r <= rc_r - 5'h1;
      irq_ret_o <= (rc_r == 5'h1);
    end
  end
endmodule : vic_cpu_model

/* File: test/testbench.sv */
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import vic_pkg::*;
  logic clk_sys_i = 1'b0;
  logic rst_i = 1'b1;
  logic [125:0] pend = '0;
  logic [117:0][2:0] prio = '0;
  logic [2:0] ipl = 3'h0;
  logic [15:0] ics = 16'h0000;
  logic [3:0] dly = 4'h0;
  logic [23:0] pm_rdata;
  logic ack;
  logic ret;
  vic_req_t irq;
  vic_fetch_t fetch;
  logic clr;
  logic [6:0] clr_idx;
  int bad_count = 0;
  int num_checks = 0;
  always #5 clk_sys_i = ~clk_sys_i;
  vic_top u_vic_top(.clk_sys_i(clk_sys_i), .rst_i(rst_i), .pend_i(pend), .prio_i(prio), .cpu_ipl_i(ipl),
    .interrupt_control_second_i(ics), .pm_rdata_i(pm_rdata), .irq_ack_i(ack), .irq_ret_i(ret),
    .irq_o(irq), .fetch_o(fetch), .clr_o(clr), .clr_idx_o(clr_idx));
  vic_cpu_model u_vic_cpu_model(.clk_sys_i(clk_sys_i), .rst_i(rst_i), .irq_i(irq), .fetch_i(fetch),
    .dly_i(dly), .pm_rdata_o(pm_rdata), .irq_ack_o(ack), .irq_ret_o(ret));
  task chk(input logic [23:0] s, input logic [23:0] e);
    num_checks++;
    if (s !== e) begin
      bad_count++;
      $display("unexpected at %0t: seen %h expected %h", $time, s, e);
    end
  endtask : chk
  task end_sim;
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : end_sim
  // one whole transfer: take, vector read, request, acknowledge, release
  task serve(input int idx, input logic alt);
    logic [23:0] a;
    int n;
    a = 24'h00_0004 + 24'(2 * idx) + (alt ? 24'h00_0100 : 24'h00_0000);
    n = 0;
    while (fetch.rd !== 1'b1 && n < 40) begin
      @(negedge clk_sys_i);
      n++;
    end
    chk(24'(fetch.rd), 24'h1);
    chk(fetch.addr, a);
    n = 0;
    while (irq.valid !== 1'b1 && n < 8) begin
      @(negedge clk_sys_i);
      n++;
    end
    chk(24'(n), 24'h2);
    chk(24'(irq.idx), 24'(idx));
    chk(irq.isr_addr, a ^ 24'hA5_0000);
    n = 0;
    while (clr !== 1'b1 && n < 20) begin
      @(negedge clk_sys_i);
      n++;
    end
    chk(24'(clr_idx), 24'(idx));
    pend[idx] = 1'b0;
  endtask : serve
  task t_levels;
    for (int l = 1; l < 8; l++) begin
      prio[l * 10] = 3'(l);
      ipl = 3'(l - 1);
      dly = 4'(l % 4);
      pend[8 + l * 10] = 1'b1;
      serve(8 + l * 10, 1'b0);
      prio[l * 10] = 3'h0;
    end
    $display("levels done");
  endtask : t_levels
  task t_order;
    ipl = 3'h0;
    ics = 16'h7FFF;
    prio[1] = 3'h2;
    prio[12] = 3'h2;
    prio[92] = 3'h5;
    prio[2] = 3'h7;
    pend[0] = 1'b1;
    pend[3] = 1'b1;
    pend[9] = 1'b1;
    pend[20] = 1'b1;
    pend[100] = 1'b1;
    pend[10] = 1'b1;
    serve(0, 1'b0);
    serve(3, 1'b0);
    serve(10, 1'b0);
    serve(100, 1'b0);
    serve(9, 1'b0);
    serve(20, 1'b0);
    prio = '0;
    $display("order done");
  endtask : t_order
  task t_alt;
    ics = 16'h8000;
    prio[117] = 3'h1;
    pend[125] = 1'b1;
    pend[7] = 1'b1;
    serve(7, 1'b1);
    serve(125, 1'b1);
    prio[117] = 3'h0;
    ics = 16'h0000;
    $display("alt done");
  endtask : t_alt
  task t_mask;
    prio[50] = 3'h3;
    ipl = 3'h3;
    pend[58] = 1'b1;
    pend[68] = 1'b1;
    repeat (16) begin
      @(negedge clk_sys_i);
      chk(24'(fetch.rd), 24'h0);
    end
    ipl = 3'h2;
    serve(58, 1'b0);
    pend[68] = 1'b0;
    $display("mask done");
  endtask : t_mask
  // reset lands on a request that the slow cpu has not yet taken
  task t_reset;
    int n;
    dly = 4'hF;
    pend[5] = 1'b1;
    n = 0;
    while (irq.valid !== 1'b1 && n < 40) begin
      @(negedge clk_sys_i);
      n++;
    end
    chk(24'(irq.idx), 24'h00_0005);
    rst_i = 1'b1;
    pend[5] = 1'b0;
    repeat (2) @(negedge clk_sys_i);
    chk(24'({irq.valid, fetch.rd, clr, clr_idx}), 24'h00_0000);
    chk(fetch.addr, 24'h00_0000);
    rst_i = 1'b0;
    $display("reset done");
  endtask : t_reset
  initial begin
    repeat (4) @(negedge clk_sys_i);
    chk(24'({irq.valid, irq.idx, clr, clr_idx}), 24'h0);
    chk(24'(fetch.rd), 24'h0);
    rst_i = 1'b0;
    t_levels();
    t_order();
    t_alt();
    t_mask();
    t_reset();
    end_sim();
  end
  initial begin
    #50us;
    bad_count++;
    end_sim();
  end
endmodule : testbench
